/* File: pcs_cfg.svh */
// constants for the program counter, return stack and indirect pointer block
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_PC_W         13
`define PCS_LOW_W        8
`define PCS_LATCH_W      5
`define PCS_STACK_DEPTH  8
`define PCS_PTR_W        3
`define PCS_OPND_W       11
`define PCS_CALL_HI_MSB  4
`define PCS_CALL_HI_LSB  3
`define PCS_INT_VECTOR   13'h0004
`define PCS_IND_SELF     7'h00
`define PCS_BANK_POS     0
`define PCS_OFF_PC_LOW   8'h00
`define PCS_OFF_LATCH    8'h04
`define PCS_OFF_FSP      8'h08
`define PCS_OFF_BANK     8'h0C
`define PCS_PC_RST       13'h0000
`define PCS_LATCH_RST    5'h00
`define PCS_FSP_RST      8'h00
`define PCS_PTR_RST      3'h0
`endif

/* File: pcs_core.sv */
// program counter, circular return stack and indirect data addressing
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "pcs_cfg.svh"

module pcs_core (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic [7:0]                  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire pcs_pkg::pcs_op_t            op,
  input  wire logic [`PCS_OPND_W-1:0]      op_operand,
  input  wire logic [7:0]                  op_low_data,
  output pcs_pkg::pcs_pc_t                 pc_out,
  input  wire logic                        file_req,
  input  wire logic                        file_we,
  input  wire logic [8:0]                  file_addr,
  input  wire logic [7:0]                  file_wdata,
  output logic      [7:0]                  file_rdata,
  output logic                             file_rvalid,
  output logic                             mem_req,
  output logic                             mem_we,
  output logic      [8:0]                  mem_addr,
  output logic      [7:0]                  mem_wdata,
  input  wire logic [7:0]                  mem_rdata
);
  import pcs_pkg::*;

  // ==========================================================
  // register bus
  logic [`PCS_LATCH_W-1:0] pc_high_latch;
  logic [`PCS_LATCH_W-1:0] next_pc_high_latch;
  logic [7:0]              file_select_pointer;
  logic [7:0]              next_file_select_pointer;
  logic                    indirect_bank_bit;
  logic                    next_indirect_bank_bit;
  logic [31:0]             next_prdata;
  logic                    apb_wr;
  logic                    mapped;
  pcs_pc_t                 pc;

  assign pready = 1'b1;
  assign apb_wr = psel & penable & pwrite;

  always_comb begin
    mapped = (paddr == `PCS_OFF_PC_LOW) || (paddr == `PCS_OFF_LATCH) ||
             (paddr == `PCS_OFF_FSP) || (paddr == `PCS_OFF_BANK);
    pslverr = psel & penable & ~mapped;
    next_pc_high_latch = pc_high_latch; // only a bus write moves it
    next_file_select_pointer = file_select_pointer;
    next_indirect_bank_bit = indirect_bank_bit;
    next_prdata = prdata;
    // read data is captured in the setup phase, so access needs no wait state
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `PCS_OFF_PC_LOW: next_prdata = {24'h00_0000, pc[7:0]};
        `PCS_OFF_LATCH:  next_prdata = {27'h000_0000, pc_high_latch};
        `PCS_OFF_FSP:    next_prdata = {24'h00_0000, file_select_pointer};
        `PCS_OFF_BANK:   next_prdata = {31'h0000_0000, indirect_bank_bit};
        default:         next_prdata = 32'h0000_0000;
      endcase
    end
    if (apb_wr) begin
      case (paddr)
        `PCS_OFF_LATCH: next_pc_high_latch = pwdata[`PCS_LATCH_W-1:0];
        `PCS_OFF_FSP:   next_file_select_pointer = pwdata[7:0];
        `PCS_OFF_BANK:  next_indirect_bank_bit = pwdata[`PCS_BANK_POS];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_high_latch <= `PCS_LATCH_RST;
      file_select_pointer <= `PCS_FSP_RST;
      indirect_bank_bit <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pc_high_latch <= next_pc_high_latch;
      file_select_pointer <= next_file_select_pointer;
      indirect_bank_bit <= next_indirect_bank_bit;
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // program counter and return stack
  // stack is internal only: no pointer port, no flags
  pcs_pc_t              next_pc;
  pcs_pc_t              stack [`PCS_STACK_DEPTH];
  pcs_pc_t              next_stack [`PCS_STACK_DEPTH];
  logic [`PCS_PTR_W-1:0] ptr;
  logic [`PCS_PTR_W-1:0] next_ptr;
  logic                  push;
  logic                  pop;
  logic                  low_wr;

  assign pc_out = pc;

  always_comb begin
    next_pc = pc;
    next_ptr = ptr;
    next_stack = stack;
    push = 1'b0;
    pop = 1'b0;
    low_wr = apb_wr && (paddr == `PCS_OFF_PC_LOW);
    // a bus write of the low byte acts as the instruction and wins
    if (low_wr) begin
      next_pc = {pc_high_latch, pwdata[7:0]};
    end else begin
      case (op)
        PCS_OP_STEP: next_pc = pc + 13'h0001;
        PCS_OP_LOW_WRITE: next_pc = {pc_high_latch, op_low_data};
        PCS_OP_GOTO: begin
          next_pc = {pc_high_latch[`PCS_CALL_HI_MSB:`PCS_CALL_HI_LSB], op_operand};
        end
        PCS_OP_CALL: begin
          push = 1'b1;
          next_stack[ptr] = pc + 13'h0001;
          next_pc = {pc_high_latch[`PCS_CALL_HI_MSB:`PCS_CALL_HI_LSB], op_operand};
        end
        PCS_OP_INT_ENTRY: begin
          push = 1'b1;
          next_stack[ptr] = pc;
          next_pc = `PCS_INT_VECTOR;
        end
        PCS_OP_RETURN, PCS_OP_RET_LIT: begin
          pop = 1'b1;
          next_pc = stack[ptr - 3'h1];
        end
        default: begin
        end
      endcase
    end
    // pointer wraps silently in both directions
    if (push) begin
      next_ptr = ptr + 3'h1;
    end else if (pop) begin
      next_ptr = ptr - 3'h1;
    end
  end

  // return from interrupt shares the plain return encoding space
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= `PCS_PC_RST;
      ptr <= `PCS_PTR_RST;
      for (int i = 0; i < `PCS_STACK_DEPTH; i++) begin
        stack[i] <= `PCS_PC_RST;
      end
    end else begin
      pc <= next_pc;
      ptr <= next_ptr;
      stack <= next_stack;
    end
  end

  // ==========================================================
  // indirect data addressing
  logic       ind_sel;
  logic       self_hit;
  logic [8:0] eff_addr;
  logic       next_mem_req;
  logic       next_mem_we;
  logic [8:0] next_mem_addr;
  logic [7:0] next_mem_wdata;
  logic       zero_rd;
  logic       next_zero_rd;
  logic       rd_pend;
  logic       next_rd_pend;
  logic [7:0] next_file_rdata;

  always_comb begin
    ind_sel = file_addr[6:0] == `PCS_IND_SELF;
    eff_addr = ind_sel ? {indirect_bank_bit, file_select_pointer} : file_addr;
    self_hit = eff_addr[6:0] == `PCS_IND_SELF;
    next_mem_req = file_req & ~self_hit;
    next_mem_we = file_req & file_we & ~self_hit;
    next_mem_addr = eff_addr;
    next_mem_wdata = file_wdata;
    next_zero_rd = file_req & ~file_we & self_hit;
    next_rd_pend = file_req & ~file_we;
    next_file_rdata = zero_rd ? 8'h00 : mem_rdata;
    if (!rd_pend) begin
      next_file_rdata = file_rdata;
    end
  end

  // two stage read: memory sees the address, the answer is then registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 9'h000;
      mem_wdata <= 8'h00;
      zero_rd <= 1'b0;
      rd_pend <= 1'b0;
      file_rdata <= 8'h00;
      file_rvalid <= 1'b0;
    end else begin
      mem_req <= next_mem_req;
      mem_we <= next_mem_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      zero_rd <= next_zero_rd;
      rd_pend <= next_rd_pend;
      file_rdata <= next_file_rdata;
      file_rvalid <= rd_pend;
    end
  end

  // ==========================================================
  // assertions
  property p_low_write_latch;
    @(posedge pclk) disable iff (!presetn)
    (op == PCS_OP_LOW_WRITE && !low_wr) |=> pc == {$past(pc_high_latch), $past(op_low_data)};
  endproperty
  a_low_write_latch: assert property (p_low_write_latch) else $error("low write pc wrong");

  property p_bus_low_write;
    @(posedge pclk) disable iff (!presetn)
    low_wr |=> pc[12:8] == $past(pc_high_latch) && pc[7:0] == $past(pwdata[7:0]);
  endproperty
  a_bus_low_write: assert property (p_bus_low_write) else $error("bus low write pc wrong");

  property p_no_carry;
    @(posedge pclk) disable iff (!presetn)
    (op == PCS_OP_LOW_WRITE && !low_wr && pc[7:0] == 8'hFF && op_low_data == 8'h00)
      |=> pc[12:8] == $past(pc_high_latch);
  endproperty
  a_no_carry: assert property (p_no_carry) else $error("carry into upper pc");

  property p_call_target;
    @(posedge pclk) disable iff (!presetn)
    (op == PCS_OP_CALL && !low_wr) |=>
      pc == {$past(pc_high_latch[4:3]), $past(op_operand)} && ptr == $past(ptr) + 3'h1;
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong");

  property p_call_ret;
    @(posedge pclk) disable iff (!presetn)
    (op == PCS_OP_CALL && !low_wr) ##1 (op == PCS_OP_RETURN && !low_wr)
      |=> pc == $past(pc, 2) + 13'h0001;
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("return address lost");

  property p_latch_kept;
    @(posedge pclk) disable iff (!presetn)
    ((push || pop) && !apb_wr) |=> $stable(pc_high_latch);
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("latch moved by stack");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    (push && ptr == 3'h7) |=> ptr == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("stack pointer did not wrap");

  property p_self_read_zero;
    @(posedge pclk) disable iff (!presetn)
    (file_req && !file_we && self_hit) |=> !mem_req ##1 (file_rvalid && file_rdata == 8'h00);
  endproperty
  a_self_read_zero: assert property (p_self_read_zero) else $error("self read not zero");

  property p_self_write_nop;
    @(posedge pclk) disable iff (!presetn)
    (file_req && file_we && self_hit) |=> !mem_we;
  endproperty
  a_self_write_nop: assert property (p_self_write_nop) else $error("self write stored");

  property p_eff_addr;
    @(posedge pclk) disable iff (!presetn)
    (file_req && ind_sel && !self_hit) |=>
      mem_req && mem_addr == {$past(indirect_bank_bit), $past(file_select_pointer)};
  endproperty
  a_eff_addr: assert property (p_eff_addr) else $error("indirect address wrong");

  property p_step;
    @(posedge pclk) disable iff (!presetn)
    (op == PCS_OP_STEP && !low_wr) |=> pc == $past(pc) + 13'h0001;
  endproperty
  a_step: assert property (p_step) else $error("pc did not advance");

  c_call: cover property (@(posedge pclk) disable iff (!presetn) op == PCS_OP_CALL);
  c_int_ret: cover property (@(posedge pclk) disable iff (!presetn)
    op == PCS_OP_INT_ENTRY ##1 op == PCS_OP_RETURN);
  c_wrap: cover property (@(posedge pclk) disable iff (!presetn) push && ptr == 3'h7);
  c_zero_read: cover property (@(posedge pclk) disable iff (!presetn)
    file_req && !file_we && self_hit);
endmodule

/* File: pcs_mem_model.sv */
// data memory partner model seen through the indirect path
`timescale 1ns/1ps
module pcs_mem_model (
  input  wire logic       pclk,
  input  wire logic       mem_req,
  input  wire logic       mem_we,
  input  wire logic [8:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] mem_rdata
);
  logic [7:0] mem [512];
  logic [7:0] last;
  initial begin
    last = 8'h00;
    for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'hA5;
  end
  // unselected: inverse of last value, so a stale read cannot match
  assign mem_rdata = mem_req ? mem[mem_addr] : ~last;
  always @(posedge pclk) begin
    if (mem_req) last <= mem[mem_addr];
    if (mem_req && mem_we) mem[mem_addr] <= mem_wdata;
  end
endmodule

/* File: pcs_pkg.sv */
// types shared by the program counter block and its users
package pcs_pkg;
  typedef enum logic [2:0] {
    PCS_OP_NONE      = 3'h0,
    PCS_OP_STEP      = 3'h1,
    PCS_OP_LOW_WRITE = 3'h2,
    PCS_OP_GOTO      = 3'h3,
    PCS_OP_CALL      = 3'h4,
    PCS_OP_INT_ENTRY = 3'h5,
    PCS_OP_RETURN    = 3'h6,
    PCS_OP_RET_LIT   = 3'h7
  } pcs_op_t;
  typedef logic [12:0] pcs_pc_t;
endpackage

/* File: test_pc_stack_indirect_addr.sv */
// self-checking bench for program counter, return stack and indirect path
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module test_pc_stack_indirect_addr;
  import pcs_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        file_req, file_we, file_rvalid, mem_req, mem_we;
  logic [7:0]  paddr, op_low_data, file_wdata, file_rdata, mem_wdata, mem_rdata;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] op_operand;
  logic [8:0]  file_addr, mem_addr;
  logic [4:0]  lat;
  logic [2:0]  sp;
  pcs_op_t     op;
  pcs_pc_t     pc_out, ep;
  pcs_pc_t     stk [8];
  int          fail_count, n_tests, cycles;

  pcs_core u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .op, .op_operand, .op_low_data, .pc_out,
    .file_req, .file_we, .file_addr, .file_wdata, .file_rdata, .file_rvalid,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);
  pcs_mem_model u_mem (.pclk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata);

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  // whole run needs little more than a hundred cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles > 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d checks %0d", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ep = 13'h0000;
    lat = 5'h00;
    sp = 3'h0;
    foreach (stk[i]) stk[i] = 13'h0000;
    @(negedge pclk);
    chk(pc_out, 32'h0000_0000, "pc after reset");
  endtask

  // bus cycle; the bench mirrors latch and pc low byte writes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && !err && a == `PCS_OFF_LATCH) lat = d[4:0];
    if (w && !err && a == `PCS_OFF_PC_LOW) ep = {lat, d[7:0]};
    @(negedge pclk);
    chk(pc_out, ep, "pc after bus cycle");
  endtask

  // one instruction action; expectation from a bench copy of pc and stack
  task automatic op1(input pcs_op_t o, input logic [10:0] t, input logic [7:0] l);
    @(posedge pclk);
    op <= o;
    op_operand <= t;
    op_low_data <= l;
    @(posedge pclk);
    op <= PCS_OP_NONE;
    case (o)
      PCS_OP_STEP: ep = ep + 13'h0001;
      PCS_OP_LOW_WRITE: ep = {lat, l};
      PCS_OP_GOTO: ep = {lat[4:3], t};
      PCS_OP_CALL: begin
        stk[sp] = ep + 13'h0001;
        sp = sp + 3'h1;
        ep = {lat[4:3], t};
      end
      PCS_OP_INT_ENTRY: begin
        stk[sp] = ep;
        sp = sp + 3'h1;
        ep = `PCS_INT_VECTOR;
      end
      PCS_OP_RETURN, PCS_OP_RET_LIT: begin
        sp = sp - 3'h1;
        ep = stk[sp];
      end
      default: ep = ep;
    endcase
    @(negedge pclk);
    chk(pc_out, ep, "pc after op");
  endtask

  task automatic fa(input logic w, input logic [8:0] a, input logic [7:0] d,
                    input logic em, input logic [8:0] ma, input logic [7:0] er);
    @(posedge pclk);
    file_req <= 1'b1;
    file_we <= w;
    file_addr <= a;
    file_wdata <= d;
    @(posedge pclk);
    file_req <= 1'b0;
    @(negedge pclk);
    chk(mem_req, em, "mem request");
    if (em) chk(mem_addr, ma, "mem address");
    chk(mem_we, w & em, "mem write enable");
    @(posedge pclk);
    @(negedge pclk);
    if (!w) chk(file_rdata, er, "indirect data");
    if (!w) chk(file_rvalid, 1'b1, "read valid");
  endtask

  // ==========================================
  // scenarios
  task automatic t_low_write();
    apb(1'b1, `PCS_OFF_LATCH, 32'hFFFF_FFFF);
    apb(1'b0, `PCS_OFF_LATCH, 32'h0000_0000);
    chk(rd, 32'h0000_001F, "latch width");
    apb(1'b1, `PCS_OFF_PC_LOW, 32'h0000_00FF);
    op1(PCS_OP_STEP, 11'h000, 8'h00);
    op1(PCS_OP_STEP, 11'h000, 8'h00);
    apb(1'b1, `PCS_OFF_LATCH, 32'h0000_0002);
    op1(PCS_OP_LOW_WRITE, 11'h000, 8'hFF);
    op1(PCS_OP_LOW_WRITE, 11'h000, 8'h00);
    apb(1'b0, `PCS_OFF_PC_LOW, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "pc low byte read");
  endtask

  task automatic t_call_ret();
    apb(1'b1, `PCS_OFF_LATCH, 32'h0000_0018);
    op1(PCS_OP_CALL, 11'h7AB, 8'h00);
    op1(PCS_OP_GOTO, 11'h123, 8'h00);
    op1(PCS_OP_INT_ENTRY, 11'h000, 8'h00);
    op1(PCS_OP_RET_LIT, 11'h000, 8'h00);
    op1(PCS_OP_RETURN, 11'h000, 8'h00);
    apb(1'b0, `PCS_OFF_LATCH, 32'h0000_0000);
    chk(rd, 32'h0000_0018, "latch kept");
  endtask

  // ops on consecutive edges: call then return, interrupt entry then return
  task automatic t_back_to_back();
    @(posedge pclk);
    op <= PCS_OP_CALL;
    op_operand <= 11'h055;
    @(posedge pclk);
    op <= PCS_OP_RETURN;
    @(negedge pclk);
    chk(pc_out, {lat[4:3], 11'h055}, "pc after quick call");
    @(posedge pclk);
    op <= PCS_OP_INT_ENTRY;
    @(negedge pclk);
    chk(pc_out, ep + 13'h0001, "pc after quick return");
    @(posedge pclk);
    op <= PCS_OP_RETURN;
    @(negedge pclk);
    chk(pc_out, `PCS_INT_VECTOR, "interrupt vector");
    @(posedge pclk);
    op <= PCS_OP_NONE;
    ep = ep + 13'h0001;
    stk[sp] = ep;
    @(negedge pclk);
    chk(pc_out, ep, "pc after interrupt return");
  endtask

  // ten pushes then nine pops: wraps without any flag
  task automatic t_wrap();
    for (int i = 1; i <= 10; i++) op1(PCS_OP_CALL, 11'(i * 8), 8'h00);
    for (int i = 0; i < 9; i++) op1(PCS_OP_RETURN, 11'h000, 8'h00);
  endtask

  task automatic t_bus_map();
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
  endtask

  task automatic t_indirect();
    apb(1'b1, `PCS_OFF_FSP, 32'h0000_0045);
    apb(1'b1, `PCS_OFF_BANK, 32'h0000_0001);
    fa(1'b0, 9'h000, 8'h00, 1'b1, 9'h145, 8'h45 ^ 8'hA5);
    fa(1'b1, 9'h000, 8'h3C, 1'b1, 9'h145, 8'h00);
    chk(u_mem.mem[9'h145], 8'h3C, "indirect store");
    fa(1'b0, 9'h033, 8'h00, 1'b1, 9'h033, 8'h33 ^ 8'hA5);
    apb(1'b1, `PCS_OFF_BANK, 32'h0000_0000);
    apb(1'b1, `PCS_OFF_FSP, 32'h0000_0080);
    fa(1'b0, 9'h000, 8'h00, 1'b0, 9'h000, 8'h00);
    fa(1'b1, 9'h000, 8'h77, 1'b0, 9'h000, 8'h00);
  endtask

  // ==========================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, file_req, file_we} = '0;
    {paddr, pwdata, op_operand, op_low_data, file_addr, file_wdata} = '0;
    op = PCS_OP_NONE;
    fail_count = 0;
    n_tests = 0;
    cycles = 0;
    do_reset();
    t_low_write();
    t_call_ret();
    t_back_to_back();
    t_wrap();
    t_bus_map();
    t_indirect();
    do_reset();
    wrap_up();
  end
endmodule
